//--- hw/ies_core.sv
// Execution unit for the bit, AND, bit-test, watchdog-clear and call instructions.
`timescale 1ns/1ps

module ies_core
    import ies_pkg::*;
#(
    parameter int unsigned CYCLE_DIV   = CYCLE_DIV_DEF,
    parameter int unsigned STACK_DEPTH = STACK_DEPTH_DEF
) (
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    // Instruction issue.
    input  wire logic                 instrValid,
    input  wire logic [2:0]           instrOp,
    input  wire logic [FADDR_W-1:0]   instrFile,
    input  wire logic [BIT_W-1:0]     instrBit,
    input  wire logic                 instrDest,
    input  wire logic [IMM_W-1:0]     instrImm,
    output logic                      instrAck,
    output logic                      instrDiscard,
    // Watchdog time base.
    input  wire logic                 wdogTick,
    // Register port.
    input  wire logic [RADDR_W-1:0]   regAddr,
    input  wire logic [DATA_W-1:0]    regWrData,
    input  wire logic                 regWrStb,
    input  wire logic                 regRdStb,
    output logic      [DATA_W-1:0]    regRdData,
    // Core state.
    output logic      [PC_W-1:0]      pcOut,
    output logic      [PC_W-1:0]      stackTop,
    output logic                      zeroFlag,
    output logic                      timeoutStatusN,
    output logic                      powerdownStatusN
);

    // ------------------------------------------------------------------
    // Elaboration checks.
    // ------------------------------------------------------------------
    localparam int unsigned DIV_W = (CYCLE_DIV > 1) ? $clog2(CYCLE_DIV) : 1;
    localparam int unsigned SP_W  = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

    // The stack pointer wraps by plain overflow, so the depth must be a power of two.
    generate
        if (CYCLE_DIV < 1 || STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad
            $error("ies_core: CYCLE_DIV must be >= 1 and STACK_DEPTH a power of two >= 2.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Types, functions and state.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_FLUSH = 2'b10
    } ies_state_t;

    // One-hot mask for a bit number; shared by bit-set and both bit tests.
    function automatic logic [DATA_W-1:0] bitMask(input logic [BIT_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = '0;
        m[sel] = 1'b1;
        return m;
    endfunction

    ies_state_t              state_r;
    ies_state_t              state_nxt;
    logic [DIV_W-1:0]        divCnt_r;
    logic [DATA_W-1:0]       accum_r;
    logic                    zero_r;
    logic                    toN_r;
    logic                    pdN_r;
    logic [PC_W-1:0]         pc_r;
    logic [PCU_W-1:0]        pcUpper_r;
    logic [DATA_W-1:0]       wdogCnt_r;
    logic [DATA_W-1:0]       wdogPre_r;
    logic [SP_W-1:0]         stackPtr_r;
    logic [PC_W-1:0]         stackTop_r;
    logic [FADDR_W-1:0]      swFileAddr_r;
    logic                    flushSkip_r;
    logic                    ack_r;
    logic                    discard_r;
    logic [DATA_W-1:0]       rdData_r;
    logic [DATA_W-1:0]       fileMem [0:(1<<FADDR_W)-1];
    logic [PC_W-1:0]         stackMem [0:STACK_DEPTH-1];

    // ------------------------------------------------------------------
    // Instruction cycle enable.
    // ------------------------------------------------------------------
    // One instruction cycle spans CYCLE_DIV sys_clk cycles, like the phased core clock.
    wire cycleEn = (divCnt_r == DIV_W'(CYCLE_DIV - 1));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_r <= '0;
        end else if (cycleEn) begin
            divCnt_r <= '0;
        end else begin
            divCnt_r <= divCnt_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------------
    wire                take      = cycleEn && instrValid && (state_r == ST_RUN);
    wire                flushTick = cycleEn && (state_r == ST_FLUSH);
    wire                isBitSet  = (instrOp == OP_BIT_SET);
    wire                isAndLit  = (instrOp == OP_AND_LIT);
    wire                isAndReg  = (instrOp == OP_AND_REG);
    wire                isTestClr = (instrOp == OP_TEST_CLR);
    wire                isTestSet = (instrOp == OP_TEST_SET);
    wire                isWdogClr = (instrOp == OP_WDOG_CLR);
    wire                isCall    = (instrOp == OP_CALL);
    wire [DATA_W-1:0]   fileRd    = fileMem[instrFile];
    wire [DATA_W-1:0]   selMask   = bitMask(instrBit);

    // Bit-set only ors in the selected bit; flags are left alone.
    wire [DATA_W-1:0]   bitSetVal = fileRd | selMask;

    // Literal form takes the low byte of the immediate, register form the file byte.
    wire [DATA_W-1:0]   andOperand = isAndLit ? instrImm[DATA_W-1:0] : fileRd;
    wire [DATA_W-1:0]   andResult  = accum_r & andOperand;
    wire                andZero    = (andResult == '0);

    // Bit tests read the file byte and decide whether the next slot is a no-op.
    wire                testedBit = |(fileRd & selMask);
    wire                doSkip    = (isTestClr && !testedBit) || (isTestSet && testedBit);

    // Destination select for the register form of AND.
    wire                fileWrIns = take && (isBitSet || (isAndReg && instrDest));
    wire                accWrIns  = take && (isAndLit || (isAndReg && !instrDest));
    wire                zeroWrIns = take && (isAndLit || isAndReg);
    wire [DATA_W-1:0]   fileWrVal = isBitSet ? bitSetVal : andResult;

    // Call target: immediate in the low bits, paging bits from the upper latch.
    wire [PC_W-1:0]     pcPlusOne = pc_r + 1'b1;
    wire [PC_W-1:0]     callTgt   = {pcUpper_r[PCU_HI:PCU_LO], instrImm};
    wire                pushEn    = take && isCall;
    wire                wdogClr   = take && isWdogClr;

    // Software access decode.
    wire                swWrAccum  = regWrStb && (regAddr == REG_ACCUM);
    wire                swWrStatus = regWrStb && (regAddr == REG_STATUS);
    wire                swWrPcu    = regWrStb && (regAddr == REG_PC_UPPER);
    wire                swWrFAddr  = regWrStb && (regAddr == REG_FILE_ADDR);
    wire                swWrFData  = regWrStb && (regAddr == REG_FILE_DATA);

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    // A skip or a call turns the following instruction slot into a no-op.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (take && (doSkip || isCall)) begin
                    state_nxt = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (flushTick) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= ST_RUN;
            flushSkip_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            if (take) begin
                flushSkip_r <= doSkip;
            end
        end
    end

    // Acknowledge every instruction taken; one offered during the no-op slot is discarded.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r     <= 1'b0;
            discard_r <= 1'b0;
        end else begin
            ack_r     <= take || (flushTick && instrValid);
            discard_r <= flushTick && instrValid;
        end
    end

    // ------------------------------------------------------------------
    // Program counter, upper latch and return stack.
    // ------------------------------------------------------------------
    // A skipped instruction still consumes its address; the call slot keeps the new target.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_r <= RST_PC;
        end else if (take) begin
            pc_r <= isCall ? callTgt : pcPlusOne;
        end else if (flushTick && flushSkip_r) begin
            pc_r <= pcPlusOne;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pcUpper_r <= RST_PCU;
        end else if (swWrPcu) begin
            pcUpper_r <= regWrData[PCU_W-1:0];
        end
    end

    // The stack is circular: an overflow silently overwrites the oldest entry.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stackPtr_r <= '0;
            stackTop_r <= RST_PC;
        end else if (pushEn) begin
            stackPtr_r <= stackPtr_r + 1'b1;
            stackTop_r <= pcPlusOne;
        end
    end

    // Stack storage has no reset; only pushed entries are meaningful.
    always_ff @(posedge sys_clk) begin
        if (pushEn) begin
            stackMem[stackPtr_r] <= pcPlusOne;
        end
    end

    // ------------------------------------------------------------------
    // Accumulator and status bits.
    // ------------------------------------------------------------------
    // An executing instruction wins over a software write in the same cycle.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            accum_r <= RST_ACCUM;
            zero_r  <= RST_ZERO;
        end else begin
            if (accWrIns) begin
                accum_r <= andResult;
            end else if (swWrAccum) begin
                accum_r <= regWrData;
            end
            if (zeroWrIns) begin
                zero_r <= andZero;
            end else if (swWrStatus) begin
                zero_r <= regWrData[STAT_ZERO_BIT];
            end
        end
    end

    // Software may clear the active-low bits; a watchdog-clear in the same cycle sets them.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            toN_r <= RST_TON;
            pdN_r <= RST_PDN;
        end else if (wdogClr) begin
            toN_r <= 1'b1;
            pdN_r <= 1'b1;
        end else if (swWrStatus) begin
            toN_r <= regWrData[STAT_TON_BIT];
            pdN_r <= regWrData[STAT_PDN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter and prescaler.
    // ------------------------------------------------------------------
    // The clear beats a tick arriving in the same cycle so the count restarts from zero.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdogPre_r <= RST_WDOG;
            wdogCnt_r <= RST_WDOG;
        end else if (wdogClr) begin
            wdogPre_r <= RST_WDOG;
            wdogCnt_r <= RST_WDOG;
        end else if (wdogTick) begin
            wdogPre_r <= wdogPre_r + 1'b1;
            if (&wdogPre_r) begin
                wdogCnt_r <= wdogCnt_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // File registers.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            swFileAddr_r <= '0;
        end else if (swWrFAddr) begin
            swFileAddr_r <= regWrData[FADDR_W-1:0];
        end
    end

    // File storage has no reset, as in a real register file; instructions win over software.
    always_ff @(posedge sys_clk) begin
        if (fileWrIns) begin
            fileMem[instrFile] <= fileWrVal;
        end else if (swWrFData) begin
            fileMem[swFileAddr_r] <= regWrData;
        end
    end

    // ------------------------------------------------------------------
    // Register read port.
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rdMux;

    // Unmapped offsets read as zero.
    always_comb begin
        rdMux = '0;
        case (regAddr)
            REG_ACCUM:     rdMux = accum_r;
            REG_STATUS:    rdMux = DATA_W'({toN_r, pdN_r, zero_r});
            REG_PC_UPPER:  rdMux = DATA_W'(pcUpper_r);
            REG_PC_LOW:    rdMux = pc_r[DATA_W-1:0];
            REG_PC_HIGH:   rdMux = DATA_W'(pc_r[PC_W-1:DATA_W]);
            REG_WDOG_CNT:  rdMux = wdogCnt_r;
            REG_WDOG_PRE:  rdMux = wdogPre_r;
            REG_STACK_PTR: rdMux = DATA_W'(stackPtr_r);
            REG_FILE_ADDR: rdMux = DATA_W'(swFileAddr_r);
            REG_FILE_DATA: rdMux = fileMem[swFileAddr_r];
            default:       rdMux = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= regRdStb ? rdMux : '0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops.
    // ------------------------------------------------------------------
    assign instrAck         = ack_r;
    assign instrDiscard     = discard_r;
    assign regRdData        = rdData_r;
    assign pcOut            = pc_r;
    assign stackTop         = stackTop_r;
    assign zeroFlag         = zero_r;
    assign timeoutStatusN   = toN_r;
    assign powerdownStatusN = pdN_r;

endmodule

//--- hw/ies_pkg.sv
// Package with the constants, opcodes and register map of the instruction execution subset.
package ies_pkg;

    // ------------------------------------------------------------------
    // Widths.
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned FADDR_W   = 7;
    localparam int unsigned BIT_W     = 3;
    localparam int unsigned IMM_W     = 11;
    localparam int unsigned PC_W      = 13;
    localparam int unsigned PCU_W     = 5;
    localparam int unsigned RADDR_W   = 4;
    localparam int unsigned PCU_LO    = 3;
    localparam int unsigned PCU_HI    = 4;

    // ------------------------------------------------------------------
    // Instruction selector presented on the issue port.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP      = 3'h0,
        OP_BIT_SET  = 3'h1,
        OP_AND_LIT  = 3'h2,
        OP_AND_REG  = 3'h3,
        OP_TEST_CLR = 3'h4,
        OP_TEST_SET = 3'h5,
        OP_WDOG_CLR = 3'h6,
        OP_CALL     = 3'h7
    } ies_op_t;

    // ------------------------------------------------------------------
    // Register map, offsets on the plain register port.
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_ACCUM     = 4'h0;
    localparam logic [3:0] REG_STATUS    = 4'h1;
    localparam logic [3:0] REG_PC_UPPER  = 4'h2;
    localparam logic [3:0] REG_PC_LOW    = 4'h3;
    localparam logic [3:0] REG_PC_HIGH   = 4'h4;
    localparam logic [3:0] REG_WDOG_CNT  = 4'h5;
    localparam logic [3:0] REG_WDOG_PRE  = 4'h6;
    localparam logic [3:0] REG_STACK_PTR = 4'h7;
    localparam logic [3:0] REG_FILE_ADDR = 4'h8;
    localparam logic [3:0] REG_FILE_DATA = 4'h9;

    // Status register field positions.
    localparam int unsigned STAT_ZERO_BIT = 0;
    localparam int unsigned STAT_PDN_BIT  = 1;
    localparam int unsigned STAT_TON_BIT  = 2;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_ACCUM  = 8'h00;
    localparam logic [12:0] RST_PC     = 13'h0000;
    localparam logic [4:0]  RST_PCU    = 5'h00;
    localparam logic [7:0]  RST_WDOG   = 8'h00;
    localparam logic        RST_ZERO   = 1'b0;
    localparam logic        RST_TON    = 1'b1;
    localparam logic        RST_PDN    = 1'b1;

    // Timing: sys_clk cycles per instruction cycle.
    localparam int unsigned CYCLE_DIV_DEF   = 4;
    localparam int unsigned STACK_DEPTH_DEF = 8;

endpackage

//--- verif/ies_core_properties.sv
// Concurrent checker for the instruction execution subset, bound to its top module.
`timescale 1ns/1ps
module ies_core_chk
    import ies_pkg::*;
#(
    parameter int unsigned CYCLE_DIV   = CYCLE_DIV_DEF,
    parameter int unsigned STACK_DEPTH = STACK_DEPTH_DEF
) (
    // Clock and reset.
    input wire logic              sys_clk,
    input wire logic              rst_b,
    // Instruction issue.
    input wire logic [2:0]        instrOp,
    input wire logic [IMM_W-1:0]  instrImm,
    input wire logic              instrAck,
    input wire logic              instrDiscard,
    // Core state.
    input wire logic [PC_W-1:0]   pcOut,
    input wire logic [PC_W-1:0]   stackTop,
    input wire logic              zeroFlag,
    input wire logic              timeoutStatusN,
    input wire logic              powerdownStatusN
);
    logic [2:0] prevOp_r;
    logic [2:0] lastOp_r;
    int unsigned slotCnt_r;
    wire        exec = instrAck && !instrDiscard;

    // Opcode seen at the take edge, last executed opcode, and an open call slot.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevOp_r   <= OP_NOP;
            lastOp_r   <= OP_NOP;
            slotCnt_r  <= 0;
        end else begin
            prevOp_r <= instrOp;
            if (instrAck) begin
                lastOp_r <= exec ? prevOp_r : lastOp_r;
            end
            // A slot acknowledge trails the call's own by CYCLE_DIV cycles; an empty slot acks nothing.
            if (exec && prevOp_r == OP_CALL) begin
                slotCnt_r <= CYCLE_DIV;
            end else if (slotCnt_r != 0) begin
                slotCnt_r <= slotCnt_r - 1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    discard_has_ack_a: assert property (instrDiscard |-> instrAck) else $error("discard without ack");
    discard_cause_a: assert property (instrDiscard |-> lastOp_r inside {OP_TEST_CLR, OP_TEST_SET, OP_CALL})
        else $error("discard after a plain instruction");
    call_target_a: assert property (exec && prevOp_r == OP_CALL |-> pcOut[10:0] == $past(instrImm))
        else $error("call target wrong");
    call_push_a: assert property (exec && prevOp_r == OP_CALL |-> stackTop == $past(pcOut) + 13'h0001)
        else $error("return address wrong");
    call_slot_a: assert property (instrAck && slotCnt_r == 1 |-> instrDiscard)
        else $error("call slot executed");
    slot_keeps_pc_a: assert property (instrAck && slotCnt_r == 1 |-> $stable(pcOut))
        else $error("call slot moved pc");
    wdog_status_a: assert property (exec && prevOp_r == OP_WDOG_CLR |-> timeoutStatusN && powerdownStatusN)
        else $error("status bits not set");
    flag_keep_a: assert property (exec && prevOp_r inside {OP_BIT_SET, OP_TEST_CLR, OP_TEST_SET, OP_CALL}
        |-> $stable(zeroFlag)) else $error("zero flag changed");
    and_zero_a: assert property (exec && prevOp_r == OP_AND_LIT && $past(instrImm[7:0]) == 8'h00 |-> zeroFlag)
        else $error("zero result without zero flag");

    // Main scenarios.
    cover property (exec && prevOp_r == OP_CALL);
    cover property (instrDiscard && lastOp_r == OP_TEST_CLR);
    cover property (instrDiscard && lastOp_r == OP_TEST_SET);
    cover property (exec && prevOp_r == OP_WDOG_CLR);
endmodule

bind ies_core ies_core_chk #(.CYCLE_DIV(CYCLE_DIV), .STACK_DEPTH(STACK_DEPTH)) u_chk (.sys_clk, .rst_b, .instrOp,
    .instrImm, .instrAck, .instrDiscard, .pcOut, .stackTop, .zeroFlag, .timeoutStatusN, .powerdownStatusN);

//--- verif/ies_core_tb.sv
// Self-checking testbench for the instruction execution subset.
`timescale 1ns/1ps
module ies_core_tb
    import ies_pkg::*;
;
    logic        sys_clk, rst_b, instrValid, instrDest, wdogTick, regWrStb, regRdStb, instrAck, instrDiscard;
    logic        zeroFlag, timeoutStatusN, powerdownStatusN, skip, rdSeen = 1'b0;
    logic [2:0]  instrOp, instrBit;
    logic [6:0]  instrFile, f;
    logic [10:0] instrImm, k;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData, regRdData, acc, v, m;
    logic [12:0] pcOut, stackTop, pc, ret;
    logic [7:0]  rdQ[$];
    logic        ackQ[$];
    int          err_count = 0, checks_done = 0;

    // One sys_clk edge per instruction cycle keeps the run short.
    ies_core #(.CYCLE_DIV(1)) dut (.sys_clk, .rst_b, .instrValid, .instrOp, .instrFile, .instrBit, .instrDest,
        .instrImm, .instrAck, .instrDiscard, .wdogTick, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
        .pcOut, .stackTop, .zeroFlag, .timeoutStatusN, .powerdownStatusN);

    // Clock at 50 ns.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic bad(string what);
        err_count++;
        $display("BAD %0t %s", $time, what);
    endtask
    task automatic cmp_rd(logic [7:0] got, logic [7:0] exp);
        checks_done++;
        if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
    endtask
    task automatic cmp_ack(logic got, logic exp);
        checks_done++;
        if (got !== exp) bad($sformatf("discard %b expected %b", got, exp));
    endtask
    task automatic cmp_pc(logic [12:0] got, logic [12:0] exp);
        checks_done++;
        if (got !== exp) bad($sformatf("address %h expected %h", got, exp));
    endtask

    // Watcher: read data stands only in the cycle after the strobe, so it is taken then.
    always @(posedge sys_clk) begin
        if (rdSeen) cmp_rd(regRdData, rdQ.pop_front());
        rdSeen = regRdStb;
        if (instrAck === 1'b1) begin
            if (ackQ.size() == 0) bad("acknowledge with no instruction offered");
            else cmp_ack(instrDiscard, ackQ.pop_front());
        end
    end

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regWrStb <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge sys_clk);
        regRdStb <= 1'b1; regAddr <= a; rdQ.push_back(e);
        @(posedge sys_clk);
        regRdStb <= 1'b0;
    endtask
    task automatic rdpc();
        rd(REG_PC_LOW, pc[7:0]);
        rd(REG_PC_HIGH, {3'h0, pc[12:8]});
    endtask
    // A chained instruction keeps valid high so the next one lands in the following slot.
    task automatic ex(logic [2:0] op, logic [6:0] fa, logic [2:0] b, logic d, logic [10:0] im, logic disc, bit chain);
        @(posedge sys_clk);
        instrValid <= 1'b1; instrOp <= op; instrFile <= fa; instrBit <= b; instrDest <= d; instrImm <= im;
        ackQ.push_back(disc);
        pc = pc + 13'h0001;
        if (!chain) begin
            @(posedge sys_clk);
            instrValid <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask

    task automatic wrap_up();
        // A result that never appeared would otherwise leave its note unchecked.
        if (rdQ.size() != 0 || ackQ.size() != 0) bad("expected results never appeared");
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad("watchdog expired");
        wrap_up();
    end

    // Main sequence.
    initial begin
        {instrValid, instrOp, instrFile, instrBit, instrDest, instrImm, wdogTick} = '0;
        {regAddr, regWrData, regWrStb, regRdStb, rst_b} = '0;
        v = $urandom(25);
        pc = 13'h0000;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(REG_STATUS, 8'h06);
        rd(REG_ACCUM, 8'h00);
        rdpc();
        wr(REG_PC_LOW, 8'h55);
        rd(REG_PC_LOW, 8'h00);
        rd(4'hF, 8'h00);
        $display("test reset done");
        wr(REG_FILE_ADDR, 8'h7F); wr(REG_FILE_DATA, 8'h00); wr(REG_STATUS, 8'h07);
        m = 8'h00;
        for (int b = 0; b < 8; b++) begin
            ex(OP_BIT_SET, 7'h7F, b[2:0], 1'b0, 11'h000, 1'b0, 1'b0);
            m[b] = 1'b1;
            rd(REG_FILE_DATA, m);
        end
        rd(REG_STATUS, 8'h07);
        $display("test bit set done");
        acc = $urandom;
        wr(REG_ACCUM, acc);
        for (int i = 0; i < 5; i++) begin
            v = (i == 4) ? 8'h00 : 8'($urandom);
            ex(OP_AND_LIT, 7'h00, 3'h0, 1'b0, {3'($urandom), v}, 1'b0, 1'b0);
            acc = acc & v;
            rd(REG_ACCUM, acc);
            rd(REG_STATUS, {7'h03, acc == 8'h00});
        end
        $display("test and literal done");
        for (int d = 0; d < 2; d++) begin
            f = $urandom; v = $urandom; acc = $urandom;
            wr(REG_FILE_ADDR, {1'b0, f}); wr(REG_FILE_DATA, v); wr(REG_ACCUM, acc);
            ex(OP_AND_REG, f, 3'h0, d[0], 11'h000, 1'b0, 1'b0);
            rd(REG_ACCUM, d[0] ? acc : acc & v);
            rd(REG_FILE_DATA, d[0] ? acc & v : v);
            rd(REG_STATUS, {7'h03, (acc & v) == 8'h00});
        end
        $display("test and register done");
        wr(REG_FILE_ADDR, 8'h7F); wr(REG_FILE_DATA, 8'hA5);
        for (int t = 0; t < 4; t++) begin
            skip = (t < 2) ? (t[0] == 1'b1) : (t[0] == 1'b0);
            wr(REG_ACCUM, 8'h3C); wr(REG_STATUS, 8'h06);
            ex((t < 2) ? OP_TEST_CLR : OP_TEST_SET, 7'h7F, {2'h0, t[0]}, 1'b0, 11'h000, 1'b0, 1'b1);
            ex(OP_AND_LIT, 7'h00, 3'h0, 1'b0, 11'h000, skip, 1'b0);
            rd(REG_ACCUM, skip ? 8'h3C : 8'h00);
            rd(REG_STATUS, skip ? 8'h06 : 8'h07);
            rdpc();
        end
        $display("test bit tests done");
        @(posedge sys_clk);
        wdogTick <= 1'b1;
        repeat (260) @(posedge sys_clk);
        wdogTick <= 1'b0;
        rd(REG_WDOG_PRE, 8'h04);
        rd(REG_WDOG_CNT, 8'h01);
        wr(REG_STATUS, 8'h00);
        ex(OP_WDOG_CLR, 7'h00, 3'h0, 1'b0, 11'h000, 1'b0, 1'b0);
        rd(REG_WDOG_CNT, 8'h00);
        rd(REG_WDOG_PRE, 8'h00);
        rd(REG_STATUS, 8'h06);
        $display("test watchdog clear done");
        wr(REG_PC_UPPER, 8'h18); wr(REG_ACCUM, 8'hFF);
        k = $urandom;
        ret = pc + 13'h0001;
        ex(OP_CALL, 7'h00, 3'h0, 1'b0, k, 1'b0, 1'b1);
        ex(OP_AND_LIT, 7'h00, 3'h0, 1'b0, 11'h000, 1'b1, 1'b0);
        cmp_pc(stackTop, ret);
        pc = {2'b11, k};
        rdpc();
        cmp_pc(pcOut, pc);
        rd(REG_ACCUM, 8'hFF);
        rd(REG_STATUS, 8'h06);
        $display("test call done");
        // Let the watcher take the last read before the queues are checked.
        repeat (3) @(posedge sys_clk);
        wrap_up();
    end
endmodule
